// file: hdl/srl_loop_counter.sv
`timescale 1ns/1ps
// reset loop counting register; exit when its low byte reaches zero
module srl_loop_counter (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control
	input wire logic load,
	input wire logic step,
	// state
	output logic [7:0] count,
	output logic done
);
	typedef struct packed {
		logic [7:0] count;
	} srl_cnt_t;
	srl_cnt_t r, next_r;

	// decrement per pass; load wins over step
	always_comb begin
		next_r = r;
		if (load) begin
			next_r.count = srl_pkg::LOOP_COUNT_INIT;
		end else if (step && r.count != 8'h00) begin
			next_r.count = r.count - 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign count = r.count;
	assign done = (r.count == 8'h00);
endmodule : srl_loop_counter

// file: hdl/srl_pkg.sv
package srl_pkg;
	// control store entry points of the reset and load routines
	localparam logic [11:0] CS_RESET_ENTRY = 12'h242;
	localparam logic [11:0] CS_LOAD_ENTRY = 12'h240;
	// mode field value that selects the reset/load exit branch
	localparam logic [1:0] MODE_RESET = 2'h3;
	// channel save area fill values
	localparam logic [31:0] SAVE_FIRST_WORD = 32'h00000000;
	localparam logic [31:0] SAVE_OTHER_WORD = 32'h07000000;
	localparam int SAVE_WORDS_PER_SUB = 4;
	// reset loop counting register start (low byte counts to zero)
	localparam logic [7:0] LOOP_COUNT_INIT = 8'hFF;
	localparam int LS_WORDS = 64;
	localparam int WORK_REGS = 6;
	// storage byte addresses of the load area
	localparam logic [23:0] ADDR_NEW_PSW = 24'h000000;
	localparam logic [23:0] ADDR_CCW1 = 24'h000008;
	localparam logic [23:0] ADDR_CCW2 = 24'h000010;
	localparam int LOAD_BYTES = 24;
	// channel condition codes
	localparam logic [1:0] COND_ACCEPTED = 2'h0;
	localparam logic [1:0] COND_CHAN_END = 2'h1;
	localparam logic [1:0] COND_BUSY = 2'h2;
	// status word field checks
	localparam int PSW_WAIT_BIT = 14;
	localparam logic [7:0] CHAN_STAT_MASK = 8'h3F;
	localparam logic [7:0] CHAN_STAT_WANT = 8'h00;
	// unit status msb is bit 33; bits 33, 34 and 37 are don't-care
	localparam logic [6:0] UNIT_STAT_MASK = 7'h1B;
	localparam logic [6:0] UNIT_STAT_WANT = 7'h08;
	localparam int IO_ADDR_W = 11;

	// sequencer states
	typedef enum logic [4:0] {
		SRL_IDLE = 5'b00000,
		SRL_ENTRY = 5'b00001,
		SRL_LOOP = 5'b00010,
		SRL_EXIT = 5'b00011,
		SRL_RESTORE = 5'b00100,
		SRL_HALT = 5'b00101,
		SRL_SETUP = 5'b00110,
		SRL_START_IO = 5'b00111,
		SRL_WAIT_START = 5'b01000,
		SRL_START_REFUSED = 5'b01001,
		SRL_TEST_IO = 5'b01010,
		SRL_WAIT_TEST = 5'b01011,
		SRL_CHECK = 5'b01100,
		SRL_CHAN_BAD = 5'b01101,
		SRL_UNIT_BAD = 5'b01110,
		SRL_ADDR_WRITE = 5'b01111,
		SRL_PSW_LOAD = 5'b10000,
		SRL_RUN = 5'b10001
	} srl_state_t;
endpackage : srl_pkg

// file: hdl/srl_sequencer.sv
`timescale 1ns/1ps
// Contract
// - any system reset stops the processor and drops all pending interruptions; here one raised in the request cycle stays pending.
// - reset goes to every channel; channels reset their on-line interfaces.
// - save area rewritten: first word per subchannel zero, others 07000000.
// - system reset clears the instruction address register.
// - every local store word and six working registers get good parity.
// - reset clears errors, test registers, triggers and scan stat; later errors show.
// - reset and power-on enter at 242; load and restart join midway.
// - load enters at 240, clears holding registers, mode 3, stat three set.
// - loop decrements counter; emit plus counter bits address; low byte zero ends.
// - exit with stat three 0 and mode 3 restores status bits, halts.
// - exit with mode 3 and stat three 1 enters initial load.
// - first 24 bytes to 0-23: status word, command, chained command.
// - prepare command, address, clear stat three, set stat seven, start I/O.
// - response sets stat three; nonzero code loops, zero means accepted.
// - clear stat seven, test I/O, repeat on busy until channel end.
// - channel status 40-47 must match XX000000 else stall.
// - unit status 33-39 must match, else stall; then load status word.
// - write I/O address into word zero bits 21-31, clear 16-20.
// - load done: indicator off, run new word, take pending interruptions first.
// - loaded status word bit 14 one means wait state.
// - failed transfer or status load idles with load indicator on.
// - load request does full system reset, then reads selected unit.
// - load address is 11 bits: 3-bit channel, two hex device digits.
module srl_sequencer (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// operator and power requests (one-cycle pulses)
	input wire logic powerOnReq,
	input wire logic systemResetReq,
	input wire logic restartReq,
	input wire logic loadReq,
	// load unit switches
	input wire logic [2:0] loadChannelSel,
	input wire logic [3:0] loadDeviceHigh,
	input wire logic [3:0] loadDeviceLow,
	// error raised during initialisation
	input wire logic errorEvent,
	// pending interruption request from outside
	input wire logic interruptReq,
	// channel side
	output logic channelReset,
	output logic startIo,
	output logic testIo,
	output logic [10:0] ioAddress,
	input wire logic channelResponse,
	input wire logic [1:0] conditionCode,
	input wire logic [7:0] channelStatus,
	input wire logic [6:0] unitStatus,
	// storage write port
	output logic storeWrite,
	output logic [23:0] storeAddr,
	output logic [31:0] storeData,
	output logic [31:0] storeMask,
	// storage read of the new status word (first 32 bits)
	output logic storeRead,
	input wire logic storeReadValid,
	input wire logic storeReadOk,
	input wire logic [31:0] storeReadData,
	// local store parity pass
	output logic localStoreFix,
	output logic [5:0] localStoreAddr,
	output logic [5:0] workRegFix,
	// processor status
	output logic stopped,
	output logic loadIndicator,
	output logic waitState,
	output logic runStart,
	output logic takePending,
	output logic interruptPending,
	output logic errorIndicator,
	output logic testOpClear,
	output logic restoreStatus,
	output logic [11:0] controlStoreAddr,
	output logic [31:0] instructionAddress,
	output logic [31:0] programStatusWord,
	output logic [1:0] modeField,
	output logic statThree,
	output logic statSeven
);
	typedef struct packed {
		srl_pkg::srl_state_t state;
		logic [11:0] csAddr;
		logic [1:0] mode;
		logic s3;
		logic s7;
		logic stopped;
		logic loadInd;
		logic waitSt;
		logic pending;
		logic errInd;
		logic [31:0] instruction_address_reg;
		logic [31:0] program_status_word;
		logic [10:0] ioAddr;
		logic [23:0] saveAddr;
		logic [1:0] saveWord;
		logic [1:0] lsEmit;
		logic wr;
		logic [23:0] wAddr;
		logic [31:0] wData;
		logic [31:0] wMask;
		logic startIo;
		logic testIo;
		logic chanRst;
		logic runStart;
		logic takePend;
		logic lsFix;
		logic [5:0] regFix;
		logic testClr;
		logic restore;
		logic rd;
	} srl_seq_t;
	srl_seq_t r, next_r;

	logic [7:0] loopCount;
	logic loopDone;
	logic loopLoad;
	logic loopStep;
	logic resetReq;
	logic anyReq;
	logic [10:0] switchAddr;

	assign resetReq = powerOnReq | systemResetReq;
	assign anyReq = resetReq | restartReq | loadReq;
	// channel number on top, device digits below
	assign switchAddr = {loadChannelSel, loadDeviceHigh, loadDeviceLow};
	assign loopLoad = anyReq;
	assign loopStep = (r.state == srl_pkg::SRL_LOOP);

	srl_loop_counter u_loop (
		.clock(clock),
		.rst(rst),
		.load(loopLoad),
		.step(loopStep),
		.count(loopCount),
		.done(loopDone)
	);

	// sequencer next state
	always_comb begin
		next_r = r;
		next_r.wr = 1'b0;
		next_r.startIo = 1'b0;
		next_r.testIo = 1'b0;
		next_r.chanRst = 1'b0;
		next_r.runStart = 1'b0;
		next_r.takePend = 1'b0;
		next_r.lsFix = 1'b0;
		next_r.regFix = '0;
		next_r.testClr = 1'b0;
		next_r.restore = 1'b0;
		next_r.rd = 1'b0;
		// set wins over the reset clear of the same cycle
		if (interruptReq) begin
			next_r.pending = 1'b1;
		end
		if (anyReq) begin
			// every entry performs the full reset first
			next_r.state = srl_pkg::SRL_ENTRY;
			next_r.stopped = 1'b1;
			next_r.pending = interruptReq;
			// an error in the request cycle still shows
			next_r.errInd = errorEvent;
			next_r.testClr = 1'b1;
			next_r.chanRst = 1'b1;
			next_r.instruction_address_reg = '0;
			next_r.saveAddr = '0;
			next_r.saveWord = '0;
			next_r.lsEmit = '0;
			next_r.waitSt = 1'b0;
			next_r.mode = srl_pkg::MODE_RESET;
			if (loadReq) begin
				next_r.csAddr = srl_pkg::CS_LOAD_ENTRY;
				next_r.s3 = 1'b1;
				next_r.loadInd = 1'b1;
				next_r.ioAddr = switchAddr;
			end else if (resetReq) begin
				next_r.csAddr = srl_pkg::CS_RESET_ENTRY;
				next_r.s3 = 1'b0;
				next_r.loadInd = 1'b0;
			end else begin
				// restart joins the common routine directly
				next_r.csAddr = srl_pkg::CS_RESET_ENTRY + 12'h001;
				next_r.s3 = 1'b0;
				next_r.loadInd = 1'b0;
			end
		end else begin
			if (errorEvent) begin
				next_r.errInd = 1'b1;
			end
			case (r.state)
				srl_pkg::SRL_IDLE: begin
				end
				srl_pkg::SRL_ENTRY: begin
					next_r.csAddr = srl_pkg::CS_RESET_ENTRY + 12'h001;
					next_r.state = srl_pkg::SRL_LOOP;
				end
				srl_pkg::SRL_LOOP: begin
					if (loopDone) begin
						next_r.state = srl_pkg::SRL_EXIT;
					end else begin
						// save area fill in parallel with local store parity pass
						next_r.wr = 1'b1;
						next_r.wAddr = r.saveAddr;
						next_r.wMask = 32'hFFFFFFFF;
						next_r.wData = (r.saveWord == 2'h0) ? srl_pkg::SAVE_FIRST_WORD
							: srl_pkg::SAVE_OTHER_WORD;
						next_r.saveWord = r.saveWord + 2'h1;
						next_r.saveAddr = r.saveAddr + 24'h000004;
						next_r.lsFix = 1'b1;
						next_r.lsEmit = r.lsEmit + 2'h1;
						next_r.regFix = 6'h3F;
					end
				end
				srl_pkg::SRL_EXIT: begin
					if (r.mode == srl_pkg::MODE_RESET && r.s3) begin
						next_r.state = srl_pkg::SRL_SETUP;
					end else begin
						next_r.state = srl_pkg::SRL_RESTORE;
					end
				end
				srl_pkg::SRL_RESTORE: begin
					next_r.restore = 1'b1;
					next_r.state = srl_pkg::SRL_HALT;
				end
				srl_pkg::SRL_HALT: begin
					next_r.stopped = 1'b1;
				end
				srl_pkg::SRL_SETUP: begin
					// second command word and zero command address prepared
					next_r.stopped = 1'b0;
					next_r.s3 = 1'b0;
					next_r.s7 = 1'b1;
					next_r.state = srl_pkg::SRL_START_IO;
				end
				srl_pkg::SRL_START_IO: begin
					next_r.startIo = 1'b1;
					next_r.state = srl_pkg::SRL_WAIT_START;
				end
				srl_pkg::SRL_WAIT_START: begin
					if (channelResponse) begin
						next_r.s3 = 1'b1;
						next_r.state = (conditionCode == srl_pkg::COND_ACCEPTED)
							? srl_pkg::SRL_TEST_IO : srl_pkg::SRL_START_REFUSED;
					end
				end
				srl_pkg::SRL_START_REFUSED: begin
					// start refused: hang with load indicator on
					next_r.s3 = 1'b0;
				end
				srl_pkg::SRL_TEST_IO: begin
					next_r.s3 = 1'b0;
					next_r.s7 = 1'b0;
					next_r.testIo = 1'b1;
					next_r.state = srl_pkg::SRL_WAIT_TEST;
				end
				srl_pkg::SRL_WAIT_TEST: begin
					if (channelResponse) begin
						next_r.s3 = 1'b1;
						if (conditionCode == srl_pkg::COND_CHAN_END) begin
							next_r.state = srl_pkg::SRL_CHECK;
						end else if (conditionCode == srl_pkg::COND_BUSY) begin
							next_r.state = srl_pkg::SRL_TEST_IO;
						end else begin
							next_r.state = srl_pkg::SRL_START_REFUSED;
						end
					end
				end
				srl_pkg::SRL_CHECK: begin
					if ((channelStatus & srl_pkg::CHAN_STAT_MASK) != srl_pkg::CHAN_STAT_WANT) begin
						next_r.state = srl_pkg::SRL_CHAN_BAD;
					end else if ((unitStatus & srl_pkg::UNIT_STAT_MASK)
						!= srl_pkg::UNIT_STAT_WANT) begin
						next_r.state = srl_pkg::SRL_UNIT_BAD;
					end else begin
						next_r.state = srl_pkg::SRL_ADDR_WRITE;
					end
				end
				srl_pkg::SRL_CHAN_BAD, srl_pkg::SRL_UNIT_BAD: begin
					next_r.loadInd = 1'b1;
				end
				srl_pkg::SRL_ADDR_WRITE: begin
					// big-endian bit 0 is msb: bits 16-31 are the low half
					next_r.wr = 1'b1;
					next_r.wAddr = srl_pkg::ADDR_NEW_PSW;
					next_r.wMask = 32'h0000FFFF;
					next_r.wData = {16'h0000, 5'h00, r.ioAddr};
					next_r.rd = 1'b1;
					next_r.state = srl_pkg::SRL_PSW_LOAD;
				end
				srl_pkg::SRL_PSW_LOAD: begin
					if (storeReadValid) begin
						if (storeReadOk) begin
							next_r.program_status_word = storeReadData;
							next_r.waitSt = storeReadData[31 - srl_pkg::PSW_WAIT_BIT];
							next_r.loadInd = 1'b0;
							next_r.runStart = 1'b1;
							next_r.takePend = r.pending | interruptReq;
							next_r.pending = 1'b0;
							next_r.state = srl_pkg::SRL_RUN;
						end else begin
							next_r.state = srl_pkg::SRL_START_REFUSED;
						end
					end
				end
				srl_pkg::SRL_RUN: begin
				end
				default: begin
					next_r.state = srl_pkg::SRL_IDLE;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clock) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from state flops
	assign channelReset = r.chanRst;
	assign startIo = r.startIo;
	assign testIo = r.testIo;
	assign ioAddress = r.ioAddr;
	assign storeWrite = r.wr;
	assign storeAddr = r.wAddr;
	assign storeData = r.wData;
	assign storeMask = r.wMask;
	assign storeRead = r.rd;
	assign localStoreFix = r.lsFix;
	// upper counter nibble moves every 16 passes, so the emit bits reach all 64 words
	assign localStoreAddr = {r.lsEmit, loopCount[7:4]};
	assign workRegFix = r.regFix;
	assign stopped = r.stopped;
	assign loadIndicator = r.loadInd;
	assign waitState = r.waitSt;
	assign runStart = r.runStart;
	assign takePending = r.takePend;
	assign interruptPending = r.pending;
	assign errorIndicator = r.errInd;
	assign testOpClear = r.testClr;
	assign restoreStatus = r.restore;
	assign controlStoreAddr = r.csAddr;
	assign instructionAddress = r.instruction_address_reg;
	assign programStatusWord = r.program_status_word;
	assign modeField = r.mode;
	assign statThree = r.s3;
	assign statSeven = r.s7;
endmodule : srl_sequencer

// file: verification/srl_channel_model.sv
`timescale 1ns/1ps
// far-side channel and storage answering start, test and status-word reads
module srl_channel_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// requests from the sequencer
	input wire logic channelReset,
	input wire logic startIo,
	input wire logic testIo,
	input wire logic storeRead,
	// behaviour chosen by the bench
	input wire logic [1:0] startCc,
	input wire logic [1:0] busyN,
	input wire logic [2:0] delay,
	input wire logic readOk,
	input wire logic [31:0] pswWord,
	// answers
	output logic channelResponse,
	output logic [1:0] conditionCode,
	output logic storeReadValid,
	output logic storeReadOk,
	output logic [31:0] storeReadData
);
	logic ioPend, isTest, rdPend;
	logic [2:0] ioCnt, rdCnt;
	logic [1:0] busyLeft;
	// idle lines toggle each cycle so a stale answer never passes as fresh
	always @(posedge clock) begin
		channelResponse <= 1'b0;
		storeReadValid <= 1'b0;
		conditionCode <= ~conditionCode;
		storeReadOk <= ~storeReadOk;
		storeReadData <= ~storeReadData;
		if (rst || channelReset) begin
			ioPend <= 1'b0;
			rdPend <= 1'b0;
			busyLeft <= busyN;
			conditionCode <= 2'h0;
			storeReadOk <= 1'b0;
			storeReadData <= 32'h00000000;
		end else begin
			if (startIo || testIo) begin
				ioPend <= 1'b1;
				isTest <= testIo;
				ioCnt <= delay;
			end else if (ioPend && ioCnt != 3'h0) begin
				ioCnt <= ioCnt - 3'h1;
			end else if (ioPend) begin
				ioPend <= 1'b0;
				channelResponse <= 1'b1;
				if (!isTest) begin
					conditionCode <= startCc;
				end else if (busyLeft != 2'h0) begin
					conditionCode <= srl_pkg::COND_BUSY;
					busyLeft <= busyLeft - 2'h1;
				end else begin
					conditionCode <= srl_pkg::COND_CHAN_END;
				end
			end
			// status-word read answers after the same delay
			if (storeRead) begin
				rdPend <= 1'b1;
				rdCnt <= delay;
			end else if (rdPend && rdCnt != 3'h0) begin
				rdCnt <= rdCnt - 3'h1;
			end else if (rdPend) begin
				rdPend <= 1'b0;
				storeReadValid <= 1'b1;
				storeReadOk <= readOk;
				storeReadData <= pswWord;
			end
		end
	end
endmodule : srl_channel_model

// file: verification/srl_sequencer_sva.sv
`timescale 1ns/1ps
// watches the sequencer ports for entry, save-area, load and wait-state relations
module srl_sequencer_sva (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// requests
	input wire logic powerOnReq,
	input wire logic systemResetReq,
	input wire logic restartReq,
	input wire logic loadReq,
	// watched outputs
	input wire logic channelReset,
	input wire logic stopped,
	input wire logic [11:0] controlStoreAddr,
	input wire logic [31:0] instructionAddress,
	input wire logic [1:0] modeField,
	input wire logic statThree,
	input wire logic statSeven,
	input wire logic startIo,
	input wire logic testIo,
	input wire logic [10:0] ioAddress,
	input wire logic storeWrite,
	input wire logic [23:0] storeAddr,
	input wire logic [31:0] storeData,
	input wire logic [31:0] storeMask,
	input wire logic runStart,
	input wire logic waitState,
	input wire logic [31:0] programStatusWord,
	input wire logic loadIndicator,
	input wire logic restoreStatus
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// any request restarts the whole sequence
	wire anyReq = powerOnReq | systemResetReq | restartReq | loadReq;

	// entry, one cycle after the request
	a_entry_stops: assert property (anyReq |=> stopped && channelReset)
		else $error("request did not stop and reset channels");
	a_reset_entry: assert property ((powerOnReq | systemResetReq) && !loadReq |=>
		controlStoreAddr == srl_pkg::CS_RESET_ENTRY) else $error("bad reset entry");
	a_load_entry: assert property (loadReq |=> controlStoreAddr == srl_pkg::CS_LOAD_ENTRY &&
		modeField == srl_pkg::MODE_RESET && statThree) else $error("bad load entry");
	a_iar_zero: assert property (anyReq |=> instructionAddress == 32'h00000000)
		else $error("instruction address not cleared");
	// stat handling around the channel commands
	a_start_stats: assert property (startIo |-> statSeven && !statThree)
		else $error("stats wrong at start");
	a_test_stat: assert property (testIo |-> !statSeven)
		else $error("stat seven set at test");
	// save-area fill and the device address word
	a_save_words: assert property (storeWrite && storeMask == 32'hFFFFFFFF |->
		storeData == ((storeAddr[3:2] == 2'h0) ? srl_pkg::SAVE_FIRST_WORD : srl_pkg::SAVE_OTHER_WORD))
		else $error("bad save word");
	a_addr_word: assert property (storeWrite && storeMask == 32'h0000FFFF |->
		storeAddr == 24'h000000 && storeData == {21'h000000, ioAddress})
		else $error("bad address word");
	a_wait_bit: assert property (runStart |-> waitState == programStatusWord[17] &&
		!loadIndicator) else $error("wait state or load indicator wrong at run");
	a_halt_quiet: assert property (restoreStatus |=> !startIo [*8])
		else $error("start issued after halt exit");

	c_run: cover property (runStart);
	c_halt: cover property (restoreStatus);
	c_busy: cover property (testIo ##[1:20] testIo);
endmodule : srl_sequencer_sva

// file: verification/system_reset_and_initial_load_tb.sv
`timescale 1ns/1ps
module system_reset_and_initial_load_tb;
	logic clock = 1'b0, rst = 1'b1, errorEvent = 1'b0, interruptReq = 1'b0, readOk = 1'b0;
	logic powerOnReq = 1'b0, systemResetReq = 1'b0, restartReq = 1'b0, loadReq = 1'b0;
	logic [2:0] loadChannelSel = 3'h0, delay = 3'h0;
	logic [3:0] loadDeviceHigh = 4'h0, loadDeviceLow = 4'h0;
	logic [7:0] channelStatus = 8'h00;
	logic [6:0] unitStatus = 7'h00;
	logic [1:0] startCc = 2'h0, busyN = 2'h0, modeField, conditionCode;
	logic [31:0] pswWord = 32'h00000000, storeData, storeMask, storeReadData;
	logic [31:0] instructionAddress, programStatusWord;
	logic channelReset, startIo, testIo, storeWrite, storeRead, localStoreFix, stopped;
	logic loadIndicator, waitState, runStart, takePending, interruptPending, errorIndicator;
	logic testOpClear, restoreStatus, statThree, statSeven, channelResponse;
	logic storeReadValid, storeReadOk;
	logic [10:0] ioAddress, ioExp;
	logic [23:0] storeAddr;
	logic [5:0] localStoreAddr, workRegFix;
	logic [11:0] controlStoreAddr;
	logic [63:0] lsSeen;
	int mismatches = 0, n_checks = 0;
	int nWrite, nStart, nTest, nRun, nRestore, nTake, nAddr, nFix;

	srl_sequencer i_dut (.*);
	srl_channel_model i_chan (.*);

	always #10 clock = ~clock;

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// event tallies, taken once each edge has settled
	always @(posedge clock) begin
		#1;
		if (storeWrite === 1'b1 && storeMask === 32'hFFFFFFFF) begin
			check({8'h00, storeAddr}, 32'(nWrite * 4));
			nWrite++;
		end
		if (storeWrite === 1'b1 && storeMask === 32'h0000FFFF) begin
			check(storeData, {21'h000000, ioExp});
			check(storeAddr, srl_pkg::ADDR_NEW_PSW);
			check(storeRead, 1'b1);
			nAddr++;
		end
		nStart += int'(startIo === 1'b1);
		nTest += int'(testIo === 1'b1);
		nRun += int'(runStart === 1'b1);
		nRestore += int'(restoreStatus === 1'b1);
		nTake += int'(takePending === 1'b1);
		nFix += int'(localStoreFix === 1'b1);
		if (localStoreFix === 1'b1) begin
			lsSeen[localStoreAddr] = 1'b1;
			check(workRegFix, 6'h3F);
		end
	end

	// one request pulse; returns settled in the entry cycle with tallies cleared
	task automatic request(input int which);
		@(posedge clock);
		powerOnReq <= (which == 0);
		systemResetReq <= (which == 1);
		restartReq <= (which == 2);
		loadReq <= (which == 3);
		#2;
		{nWrite, nStart, nTest, nRun, nRestore, nTake, nAddr, nFix} = '0;
		lsSeen = '0;
		@(posedge clock);
		{powerOnReq, systemResetReq, restartReq, loadReq} <= 4'h0;
		#2;
	endtask : request

	// reset kinds: pending state dropped, save sweep, late error kept, then halt
	task automatic t_reset(input int which, input logic [11:0] entry);
		@(posedge clock);
		interruptReq <= 1'b1;
		errorEvent <= 1'b1;
		@(posedge clock);
		interruptReq <= 1'b0;
		errorEvent <= 1'b0;
		request(which);
		check(controlStoreAddr, entry);
		check({stopped, channelReset, testOpClear, interruptPending, errorIndicator}, 5'h1C);
		check(instructionAddress, 32'h00000000);
		check({modeField, statThree, loadIndicator}, 4'hC);
		@(posedge clock);
		errorEvent <= 1'b1;
		@(posedge clock);
		errorEvent <= 1'b0;
		repeat (300) @(posedge clock);
		#2;
		check(errorIndicator, 1'b1);
		check(nWrite, 255);
		check(nFix != 0, 1'b1);
		check(&lsSeen, 1'b1);
		check({nRestore[3:0], nStart[3:0], stopped}, 9'h021);
	endtask : t_reset

	// load with a chosen channel behaviour; outcome worked out from the status rules
	task automatic t_load(input logic [1:0] cc, input logic [1:0] busy, input logic [7:0] cs,
			input logic [6:0] us, input logic ok, input logic [31:0] program_status_word);
		logic acc, good;
		@(posedge clock);
		startCc <= cc;
		busyN <= busy;
		channelStatus <= cs;
		unitStatus <= us;
		readOk <= ok;
		pswWord <= program_status_word;
		delay <= delay + 3'h3;
		loadChannelSel <= loadChannelSel + 3'h3;
		loadDeviceHigh <= ~loadDeviceHigh;
		loadDeviceLow <= loadDeviceLow + 4'h5;
		request(3);
		ioExp = {loadChannelSel, loadDeviceHigh, loadDeviceLow};
		check(controlStoreAddr, srl_pkg::CS_LOAD_ENTRY);
		check({modeField, statThree, loadIndicator, stopped}, 5'h1F);
		check(ioAddress, ioExp);
		repeat (20) @(posedge clock);
		interruptReq <= 1'b1;
		@(posedge clock);
		interruptReq <= 1'b0;
		repeat (600) @(posedge clock);
		#2;
		acc = (cc == srl_pkg::COND_ACCEPTED);
		good = acc && (cs & 8'h3F) == 8'h00 && (us & 7'h1B) == 7'h08;
		check(nWrite, 255);
		check({nRestore[3:0], nStart[3:0]}, 8'h01);
		check(nTest, acc ? busy + 1 : 0);
		check(nAddr, good);
		check(nRun, good && ok);
		check(nTake, good && ok);
		check(loadIndicator, !(good && ok));
		if (good && ok) begin
			check(waitState, program_status_word[17]);
		end
	endtask : t_load

	// main sequence; each load also interrupts whatever the previous one left
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_reset(0, srl_pkg::CS_RESET_ENTRY);
		t_reset(1, srl_pkg::CS_RESET_ENTRY);
		t_reset(2, 12'h243);
		for (int c = 1; c < 4; c++) begin
			t_load(2'(c), 2'h0, 8'h00, 7'h08, 1'b1, 32'h00000000);
		end
		t_load(2'h0, 2'h2, 8'hC0, 7'h6C, 1'b1, 32'h00020000);
		t_load(2'h0, 2'h0, 8'h00, 7'h08, 1'b1, 32'hFFFD0000);
		t_load(2'h0, 2'h1, 8'h01, 7'h08, 1'b1, 32'h00000000);
		t_load(2'h0, 2'h0, 8'h00, 7'h18, 1'b1, 32'h00000000);
		t_load(2'h0, 2'h0, 8'h00, 7'h08, 1'b0, 32'h00000000);
		results();
	end

	// cut a hang short; the whole run needs about 5900 cycles
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		results();
	end
endmodule : system_reset_and_initial_load_tb

bind srl_sequencer srl_sequencer_sva i_sva (.*);
